//--- hdl/light_pkg.sv
package light_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int CODE_W = 7;
	localparam int COUNT_W = 12;
	localparam int BYTE_W = 8;
	localparam int FRAME_BITS = 18;

	////////////////////////////////////////////////////////////////////////////
	// Link address, value arbitrary
	localparam logic [6:0] DEV_ADDR = 7'h2A;

	////////////////////////////////////////////////////////////////////////////
	// Command register layout
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam int CMD_OSC_ON_BIT = 0;
	localparam int CMD_ADC_EN_BIT = 1;
	localparam int READ_SEL_LSB = 5;
	localparam int READ_SEL_MSB = 7;
	localparam logic [2:0] READ_SEL_CMD = 3'h0;
	localparam logic [2:0] READ_SEL_CH0 = 3'h2;
	localparam logic [2:0] READ_SEL_CH1 = 3'h4;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Ready command bytes for the host side
	localparam logic [7:0] CMD_POWER_DOWN = 8'h00;
	localparam logic [7:0] CMD_READ_CMD = 8'h03;
	localparam logic [7:0] CMD_READ_CH0 = 8'h43;
	localparam logic [7:0] CMD_READ_CH1 = 8'h83;

	////////////////////////////////////////////////////////////////////////////
	// Result register layout
	localparam int VALID_BIT = 7;
	localparam int CHORD_MSB = 6;
	localparam int CHORD_LSB = 4;
	localparam int STEP_MSB = 3;
	localparam int STEP_LSB = 0;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam logic [6:0] CODE_BELOW = 7'h00;
	localparam logic [6:0] CODE_OVERFLOW = 7'h7F;

	// Segment base counts, int(16.5 * (2^C - 1))
	localparam logic [COUNT_W-1:0] CHORD_BASE [8] = '{
		12'h000, 12'h010, 12'h031, 12'h073, 12'h0F7, 12'h1FF, 12'h40F, 12'h82F
	};

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_FREQ_KHZ = 250_000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int CONV_TIME_MS = 400;
	localparam int CONV_CYCLES = CONV_TIME_MS * CLK_FREQ_KHZ;
	localparam int SMB_PERIOD_NS = 10_000;
	localparam int QTR_CYCLES = SMB_PERIOD_NS / (4 * CLK_PERIOD_NS);

endpackage

//--- hdl/smbus_if.sv
`timescale 1ns/1ps
interface smbus_if;
	// Host drives clock, open-drain style: enable pulls low
	logic scl_o;
	logic scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl_i;
	logic sda_i;

	// Wired-AND of both ends on SDA, host end alone on SCL, with pull-up
	assign scl_i = ~(scl_oe & ~scl_o);
	assign sda_i = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport host(output scl_o, output scl_oe, output host_sda_o, output host_sda_oe, input scl_i, input sda_i);
	modport dev(output dev_sda_o, output dev_sda_oe, input scl_i, input sda_i);
endinterface

//--- hdl/light_readout_dev.sv
`timescale 1ns/1ps
// How it works
// RULE_01: One held result register per channel
// RULE_02: Bit 7 set once converter writes
// RULE_03: Bits 6-4 segment, 3-0 step
// RULE_04: All-zero code means below detection limit
// RULE_05: All-ones code means converter overflow
// RULE_06: Read returns register chosen by last select
// RULE_07: Unsigned uninverted log code, 8x16
// RULE_08: Segment base is int(16.5*(2^C-1))
// RULE_09: Count is base plus step times 2^C
// RULE_10: Power-up in power-down, converter idle
// RULE_11: Host selects channel with Send Byte
// RULE_12: Receive Byte returns selected register
// RULE_13: Ready flag zero until conversion since enable
// RULE_14: Decoded count is twelve bits unsigned
// RULE_15: Select 000 command, 010 ch0, 100 ch1
// RULE_16: Runs only with both enable bits high
// RULE_17: Results held; 400 ms per channel
// RULE_18: Send Byte zero powers down
module light_readout_dev #(
	parameter int unsigned CONV_CYCLES = light_pkg::CONV_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial link
	smbus_if.dev bus,
	// Analog front end codes
	input wire logic [1:0][light_pkg::CODE_W-1:0] front_code,
	// Decoded status
	output logic [1:0][light_pkg::COUNT_W-1:0] light_count_ff,
	output logic [1:0] count_valid_ff,
	output logic [1:0] below_limit_ff,
	output logic [1:0] overflow_ff,
	output logic converting_ff,
	output logic conv_channel_ff
);
	import light_pkg::*;

	typedef enum logic [3:0] {
		D_IDLE = 4'b0001,
		D_ADDR = 4'b0010,
		D_WRITE = 4'b0100,
		D_READ = 4'b1000
	} dev_state_e;
	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection
	logic scl_meta_ff;
	logic scl_sync_ff;
	logic scl_prev_ff;
	logic sda_meta_ff;
	logic sda_sync_ff;
	logic sda_prev_ff;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_meta_ff <= 1'b1;
			scl_sync_ff <= 1'b1;
			scl_prev_ff <= 1'b1;
			sda_meta_ff <= 1'b1;
			sda_sync_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			scl_meta_ff <= bus.scl_i;
			scl_sync_ff <= scl_meta_ff;
			scl_prev_ff <= scl_sync_ff;
			sda_meta_ff <= bus.sda_i;
			sda_sync_ff <= sda_meta_ff;
			sda_prev_ff <= sda_sync_ff;
		end
	end

	wire scl_rise = scl_sync_ff & ~scl_prev_ff;
	wire scl_fall = ~scl_sync_ff & scl_prev_ff;
	wire start_seen = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
	wire stop_seen = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;
	////////////////////////////////////////////////////////////////////////////
	// Registers
	dev_state_e state_ff;
	dev_state_e nxt_state;
	logic [3:0] bit_cnt_ff;
	logic [3:0] nxt_bit_cnt;
	logic [7:0] shift_ff;
	logic [7:0] nxt_shift;
	logic [7:0] tx_ff;
	logic [7:0] nxt_tx;
	logic [7:0] cmd_ff;
	logic [7:0] nxt_cmd;
	logic rw_ff;
	logic nxt_rw;
	logic sda_oe_ff;
	logic nxt_sda_oe;
	logic [1:0][7:0] result_ff;
	////////////////////////////////////////////////////////////////////////////
	// Read selection
	wire [2:0] read_select_field = cmd_ff[READ_SEL_MSB:READ_SEL_LSB];
	wire sel_cmd = read_select_field == READ_SEL_CMD;
	wire sel_ch0 = read_select_field == READ_SEL_CH0;
	wire sel_ch1 = read_select_field == READ_SEL_CH1;
	wire [7:0] read_byte = sel_cmd ? cmd_ff : // RULE_15
		sel_ch0 ? result_ff[0] : // RULE_15
		sel_ch1 ? result_ff[1] : UNMAPPED_READ; // RULE_15
	wire addr_match = shift_ff[7:1] == DEV_ADDR;
	wire sample_bit = scl_rise && bit_cnt_ff != 4'h8;
	////////////////////////////////////////////////////////////////////////////
	// Byte engine
	always_comb begin
		nxt_state = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_shift = shift_ff;
		nxt_tx = tx_ff;
		nxt_cmd = cmd_ff;
		nxt_rw = rw_ff;
		nxt_sda_oe = sda_oe_ff;
		if (stop_seen) begin
			nxt_state = D_IDLE;
			nxt_sda_oe = 1'b0;
		end else if (start_seen) begin
			// The START's own SCL fall wraps the count to zero
			nxt_state = D_ADDR;
			nxt_bit_cnt = 4'hF;
			nxt_sda_oe = 1'b0;
		end else begin
			unique case (state_ff)
				D_IDLE: nxt_sda_oe = 1'b0;
				D_ADDR: begin
					if (sample_bit)
						nxt_shift = {shift_ff[6:0], sda_sync_ff};
					if (scl_fall) begin
						if (bit_cnt_ff == 4'h7) begin
							nxt_bit_cnt = 4'h8;
							nxt_sda_oe = addr_match;
							nxt_rw = shift_ff[0];
						end else if (bit_cnt_ff == 4'h8) begin
							nxt_bit_cnt = 4'h0;
							if (!sda_oe_ff) begin
								nxt_state = D_IDLE;
								nxt_sda_oe = 1'b0;
							end else if (rw_ff) begin
								// Receive Byte: first data bit goes out now
								nxt_state = D_READ; // RULE_12
								nxt_tx = read_byte; // RULE_06
								nxt_sda_oe = ~read_byte[7];
							end else begin
								nxt_state = D_WRITE; // RULE_11
								nxt_sda_oe = 1'b0;
							end
						end else
							nxt_bit_cnt = bit_cnt_ff + 4'h1;
					end
				end
				D_WRITE: begin
					if (sample_bit)
						nxt_shift = {shift_ff[6:0], sda_sync_ff};
					if (scl_fall) begin
						if (bit_cnt_ff == 4'h7) begin
							nxt_bit_cnt = 4'h8;
							nxt_sda_oe = 1'b1;
							nxt_cmd = shift_ff; // RULE_18
						end else if (bit_cnt_ff == 4'h8) begin
							nxt_bit_cnt = 4'h0;
							nxt_sda_oe = 1'b0;
						end else
							nxt_bit_cnt = bit_cnt_ff + 4'h1;
					end
				end
				D_READ: begin
					if (scl_rise && bit_cnt_ff == 4'h8)
						nxt_shift = {shift_ff[6:0], sda_sync_ff};
					if (scl_fall) begin
						if (bit_cnt_ff == 4'h8) begin
							nxt_bit_cnt = 4'h0;
							if (!shift_ff[0]) begin
								// Host acked: repeat the held byte
								nxt_tx = read_byte; // RULE_17
								nxt_sda_oe = ~read_byte[7];
							end else begin
								nxt_state = D_IDLE;
								nxt_sda_oe = 1'b0;
							end
						end else if (bit_cnt_ff == 4'h7) begin
							nxt_bit_cnt = 4'h8;
							nxt_sda_oe = 1'b0;
						end else begin
							nxt_bit_cnt = bit_cnt_ff + 4'h1;
							nxt_tx = {tx_ff[6:0], 1'b0};
							nxt_sda_oe = ~tx_ff[6];
						end
					end
				end
				default: nxt_state = D_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= D_IDLE;
			bit_cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			tx_ff <= 8'h00;
			cmd_ff <= CMD_RESET; // RULE_10
			rw_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
			shift_ff <= nxt_shift;
			tx_ff <= nxt_tx;
			cmd_ff <= nxt_cmd;
			rw_ff <= nxt_rw;
			sda_oe_ff <= nxt_sda_oe;
		end
	end
	// Only ever pulls low
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = sda_oe_ff;
	////////////////////////////////////////////////////////////////////////////
	// Conversion timing, channels alternate so both take twice as long
	logic [31:0] conv_cnt_ff;
	wire run = cmd_ff[CMD_ADC_EN_BIT] & cmd_ff[CMD_OSC_ON_BIT]; // RULE_16
	wire conv_done = run && conv_cnt_ff == CONV_CYCLES - 1;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_cnt_ff <= 32'h0000_0000;
			conv_channel_ff <= 1'b0;
			converting_ff <= 1'b0;
		end else begin
			converting_ff <= run;
			if (!run) begin
				conv_cnt_ff <= 32'h0000_0000;
				conv_channel_ff <= 1'b0;
			end else if (conv_done) begin
				conv_cnt_ff <= 32'h0000_0000; // RULE_17
				conv_channel_ff <= ~conv_channel_ff;
			end else
				conv_cnt_ff <= conv_cnt_ff + 32'h0000_0001;
		end
	end
	// Unsigned, uninverted: base of the segment plus step times 2^C
	function automatic logic [COUNT_W-1:0] decode_code(input logic [CODE_W-1:0] code);
		logic [2:0] chord;
		logic [COUNT_W-1:0] step;
		chord = code[CHORD_MSB:CHORD_LSB]; // RULE_03
		step = {8'h00, code[STEP_MSB:STEP_LSB]} << chord; // RULE_09
		return CHORD_BASE[chord] + step; // RULE_08
	endfunction
	////////////////////////////////////////////////////////////////////////////
	// Per-channel result registers
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		wire capture = conv_done && conv_channel_ff == 1'(ch);
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				result_ff[ch] <= RESULT_RESET;
				light_count_ff[ch] <= 12'h000;
				count_valid_ff[ch] <= 1'b0;
				below_limit_ff[ch] <= 1'b0;
				overflow_ff[ch] <= 1'b0;
			end else if (!run) begin
				// Leaving run drops the flag, data is stale afterwards
				result_ff[ch][VALID_BIT] <= 1'b0; // RULE_13
				count_valid_ff[ch] <= 1'b0;
			end else if (capture) begin
				result_ff[ch] <= {1'b1, front_code[ch]}; // RULE_01 RULE_02 RULE_07
				light_count_ff[ch] <= decode_code(front_code[ch]); // RULE_14
				count_valid_ff[ch] <= 1'b1;
				below_limit_ff[ch] <= front_code[ch] == CODE_BELOW; // RULE_04
				overflow_ff[ch] <= front_code[ch] == CODE_OVERFLOW; // RULE_05
			end
		end
	end
endmodule

//--- hdl/light_readout_host.sv
`timescale 1ns/1ps
module light_readout_host #(
	parameter int unsigned QTR = light_pkg::QTR_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial link
	smbus_if.host bus,
	// Request
	input wire logic req_valid,
	input wire logic req_read,
	input wire logic [light_pkg::BYTE_W-1:0] req_byte,
	// Answer
	output logic busy_ff,
	output logic done_ff,
	output logic nack_ff,
	output logic [light_pkg::BYTE_W-1:0] rd_data_ff
);
	import light_pkg::*;

	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_START = 4'b0010,
		H_BITS = 4'b0100,
		H_STOP = 4'b1000
	} host_state_e;

	////////////////////////////////////////////////////////////////////////////
	// Data pin synchroniser
	logic sda_meta_ff;
	logic sda_sync_ff;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_meta_ff <= 1'b1;
			sda_sync_ff <= 1'b1;
		end else begin
			sda_meta_ff <= bus.sda_i;
			sda_sync_ff <= sda_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Quarter-period divider
	host_state_e state_ff;
	host_state_e nxt_state;
	logic [15:0] div_ff;
	logic [1:0] qtr_ff;
	logic [4:0] bit_ff;
	logic [FRAME_BITS-1:0] tx_ff;
	logic [FRAME_BITS-1:0] rx_ff;
	logic read_ff;
	logic scl_oe_ff;
	logic sda_oe_ff;

	wire tick = div_ff == 16'(QTR - 1);
	wire take = state_ff == H_IDLE && req_valid;
	// Read frame releases data and NACKs the only byte
	wire [FRAME_BITS-1:0] frame = req_read ? {DEV_ADDR, 1'b1, 1'b1, 8'hFF, 1'b1} :
		{DEV_ADDR, 1'b0, 1'b1, req_byte, 1'b1};
	wire last_bit = bit_ff == 5'(FRAME_BITS - 1);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			H_IDLE: nxt_state = req_valid ? H_START : H_IDLE;
			H_START: nxt_state = (tick && qtr_ff == 2'h1) ? H_BITS : H_START;
			H_BITS: nxt_state = (tick && qtr_ff == 2'h3 && last_bit) ? H_STOP : H_BITS;
			H_STOP: nxt_state = (tick && qtr_ff == 2'h2) ? H_IDLE : H_STOP;
			default: nxt_state = H_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= H_IDLE;
			div_ff <= 16'h0000;
			qtr_ff <= 2'h0;
			bit_ff <= 5'h00;
			tx_ff <= '0;
			rx_ff <= '0;
			read_ff <= 1'b0;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			nack_ff <= 1'b0;
			rd_data_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			done_ff <= 1'b0;
			div_ff <= (state_ff == H_IDLE || tick) ? 16'h0000 : div_ff + 16'h0001;
			if (take) begin
				tx_ff <= frame;
				read_ff <= req_read;
				busy_ff <= 1'b1;
				qtr_ff <= 2'h0;
				bit_ff <= 5'h00;
			end else if (tick) begin
				qtr_ff <= (state_ff == H_BITS) ? qtr_ff + 2'h1 : (nxt_state != state_ff ? 2'h0 : qtr_ff + 2'h1);
				unique case (state_ff)
					H_START: begin
						if (qtr_ff == 2'h0) begin
							sda_oe_ff <= 1'b1;
						end else begin
							scl_oe_ff <= 1'b1;
						end
					end
					H_BITS: begin
						unique case (qtr_ff)
							2'h0: sda_oe_ff <= ~tx_ff[FRAME_BITS-1];
							2'h1: scl_oe_ff <= 1'b0;
							2'h2: rx_ff <= {rx_ff[FRAME_BITS-2:0], sda_sync_ff};
							2'h3: begin
								scl_oe_ff <= 1'b1;
								tx_ff <= {tx_ff[FRAME_BITS-2:0], 1'b1};
								bit_ff <= last_bit ? 5'h00 : bit_ff + 5'h01;
							end
						endcase
					end
					H_STOP: begin
						if (qtr_ff == 2'h0) begin
							sda_oe_ff <= 1'b1;
						end else if (qtr_ff == 2'h1) begin
							scl_oe_ff <= 1'b0;
						end else begin
							sda_oe_ff <= 1'b0;
							busy_ff <= 1'b0;
							done_ff <= 1'b1;
							nack_ff <= rx_ff[9] | (~read_ff & rx_ff[0]);
							rd_data_ff <= rx_ff[8:1];
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	assign bus.scl_o = 1'b0;
	assign bus.scl_oe = scl_oe_ff;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe = sda_oe_ff;

endmodule

//--- tb/readout_link_checker.sv
`timescale 1ns/1ps
module readout_link_checker (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Link signals
	input wire logic scl_oe,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl_i,
	input wire logic sda_i
);
	logic scl_q_ff;
	logic sda_q_ff;
	logic rw_ff;
	logic [4:0] bit_ff;
	wire start_w = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
	wire stop_w = scl_i & scl_q_ff & ~sda_q_ff & sda_i;
	wire rise_w = scl_i & ~scl_q_ff;
	wire data_w = (bit_ff >= 5'd9) && (bit_ff <= 5'd16);

	// Counts SCL rises since START, so each check knows its bit slot
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
			bit_ff <= 5'd0;
			rw_ff <= 1'b0;
		end else begin
			scl_q_ff <= scl_i;
			sda_q_ff <= sda_i;
			if (start_w)
				bit_ff <= 5'd0;
			else if (rise_w)
				bit_ff <= bit_ff + 5'd1;
			if (rise_w && bit_ff == 5'd7)
				rw_ff <= sda_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_reset_idle_bus: assert property ($rose(rst_n) |-> !scl_oe && !host_sda_oe && !dev_sda_oe)
		else $error("bus not idle after reset");
	a_dev_scl_low: assert property ($changed(dev_sda_oe) |-> !scl_i)
		else $error("device moved SDA while SCL high");
	a_scl_high_hold: assert property ($rose(scl_i) |-> scl_i [*8])
		else $error("SCL high too short");
	a_addr_quiet: assert property (rise_w && bit_ff < 5'd8 |-> !dev_sda_oe)
		else $error("device drove SDA in address");
	a_addr_ack: assert property (rise_w && bit_ff == 5'd8 |-> !sda_i)
		else $error("address not acknowledged");
	a_last_ack: assert property (rise_w && bit_ff == 5'd17 |-> sda_i == rw_ff)
		else $error("wrong final acknowledge");
	a_host_releases: assert property (rise_w && rw_ff && data_w |-> !host_sda_oe)
		else $error("host drove SDA in read data");
	a_write_dev_quiet: assert property (rise_w && !rw_ff && data_w |-> !dev_sda_oe)
		else $error("device drove SDA in write data");
	a_stop_idle: assert property (stop_w |=> (!scl_oe && !dev_sda_oe) [*8])
		else $error("bus busy right after STOP");
endmodule

//--- tb/tb_companded_light_adc_readout.sv
`timescale 1ns/1ps
module tb_companded_light_adc_readout;
	import light_pkg::*;
	// Short conversion and fast link clock keep the run near ten thousand cycles
	localparam int CONV = 200;
	localparam int QTR = 10;
	localparam int LIMIT = 20_000;
	logic ref_clk;
	logic rst_n;
	logic req_valid;
	logic req_read;
	logic [7:0] req_byte;
	logic [1:0][CODE_W-1:0] front_code;
	logic [1:0][COUNT_W-1:0] light_count_ff;
	logic [1:0] count_valid_ff, below_limit_ff, overflow_ff;
	logic converting_ff, conv_channel_ff, busy_ff, done_ff, nack_ff;
	logic [7:0] rd_data_ff;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;

	smbus_if smbus_if_i();
	light_readout_dev #(.CONV_CYCLES(CONV)) light_readout_dev_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.bus(smbus_if_i), .front_code(front_code), .light_count_ff(light_count_ff),
		.count_valid_ff(count_valid_ff), .below_limit_ff(below_limit_ff), .overflow_ff(overflow_ff),
		.converting_ff(converting_ff), .conv_channel_ff(conv_channel_ff));
	light_readout_host #(.QTR(QTR)) light_readout_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .bus(smbus_if_i),
		.req_valid(req_valid), .req_read(req_read), .req_byte(req_byte), .busy_ff(busy_ff),
		.done_ff(done_ff), .nack_ff(nack_ff), .rd_data_ff(rd_data_ff));
	readout_link_checker readout_link_checker_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.scl_oe(smbus_if_i.scl_oe), .host_sda_oe(smbus_if_i.host_sda_oe),
		.dev_sda_oe(smbus_if_i.dev_sda_oe), .scl_i(smbus_if_i.scl_i), .sda_i(smbus_if_i.sda_i));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_fail++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lin(input int c, input int s);
		return 16'((33 * ((1 << c) - 1)) / 2 + s * (1 << c));
	endfunction

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, seen);
			n_fail++;
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic xfer(input logic rd, input logic [7:0] b);
		int n;
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_read <= rd;
		req_byte <= b;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		n = 0;
		#1;
		chk("busy", 16'(busy_ff), 16'h0001);
		while (done_ff !== 1'b1 && n < 2_000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk("done", 16'(done_ff), 16'h0001);
		chk("idle", 16'(busy_ff), 16'h0000);
		chk("nack", 16'(nack_ff), 16'h0000);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_power_up;
		@(posedge ref_clk);
		front_code <= {7'h00, 7'h7F};
		xfer(1'b0, CMD_READ_CH1);
		wait_cyc(2 * CONV + 8);
		chk("run", 16'(converting_ff), 16'h0001);
		chk("valid", 16'(count_valid_ff), 16'h0003);
		chk("ovf", 16'(overflow_ff), 16'h0001);
		chk("below", 16'(below_limit_ff), 16'h0002);
		chk("count0", 16'(light_count_ff[0]), lin(7, 15));
		$display("test power_up done");
	endtask

	task automatic t_decode;
		for (int c = 0; c < 8; c++) begin
			@(posedge ref_clk);
			front_code[0] <= {3'(c), 4'(15 - 2 * c)};
			front_code[1] <= {3'(c), 4'(2 * c)};
			wait_cyc(2 * CONV + 8);
			chk("count0", 16'(light_count_ff[0]), lin(c, 15 - 2 * c));
			chk("count1", 16'(light_count_ff[1]), lin(c, 2 * c));
		end
		$display("test decode done");
	endtask

	task automatic t_read;
		@(posedge ref_clk);
		front_code <= {7'h5A, 7'h35};
		wait_cyc(2 * CONV + 8);
		xfer(1'b1, 8'h00);
		chk("rd ch1", 16'(rd_data_ff), 16'h00DA);
		$display("test read done");
	endtask

	task automatic t_power_down;
		xfer(1'b0, CMD_POWER_DOWN);
		@(posedge ref_clk);
		front_code <= {7'h11, 7'h22};
		wait_cyc(2 * CONV + 8);
		chk("valid", 16'(count_valid_ff), 16'h0000);
		chk("run", 16'(converting_ff), 16'h0000);
		chk("chan", 16'(conv_channel_ff), 16'h0000);
		chk("held", 16'(light_count_ff[0]), lin(3, 5));
		xfer(1'b1, 8'h00);
		chk("rd cmd", 16'(rd_data_ff), 16'(CMD_POWER_DOWN));
		$display("test power_down done");
	endtask

	task automatic t_reenable;
		xfer(1'b0, CMD_READ_CH0);
		chk("valid", 16'(count_valid_ff), 16'h0000);
		wait_cyc(2 * CONV + 8);
		chk("valid", 16'(count_valid_ff), 16'h0003);
		xfer(1'b1, 8'h00);
		chk("rd ch0", 16'(rd_data_ff), 16'h00A2);
		$display("test reenable done");
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_read = 1'b0;
		req_byte = 8'h00;
		front_code = '0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		wait_cyc(1);
		chk("valid", 16'(count_valid_ff), 16'h0000);
		chk("run", 16'(converting_ff), 16'h0000);
		$display("test reset done");
		t_power_up();
		t_decode();
		t_read();
		t_power_down();
		t_reenable();
		give_verdict();
	end
endmodule
